// ### hdl/flash_core_ctrl.sv
// Core end: issues register accesses and runs erase or program orders.
`timescale 1ns/1ps
`default_nettype none
module flash_core_ctrl
    import flash_seq_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    // User order.
    input  wire logic              i_start,
    input  wire logic              i_erase,
    input  wire logic              i_last,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_data,
    output logic                   o_ready,
    // Link to the sequencer.
    flash_seq_if.core              bus
);
    logic [2:0] step_ff;
    logic       act_ff;
    logic [7:0] ctl_val;
    logic [2:0] a_ff;
    logic [7:0] d_ff;
    logic       wr_ff;

    // Order of writes: address, data, control, keys, trigger.
    assign ctl_val = i_erase ? 8'h14 : (i_last ? 8'h04 : 8'h24);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_ff <= '0;
            act_ff  <= 1'b0;
            a_ff    <= '0;
            d_ff    <= '0;
            wr_ff   <= 1'b0;
        end else begin
            wr_ff <= 1'b0;
            if (!act_ff) begin
                if (i_start) begin
                    act_ff  <= 1'b1;
                    step_ff <= '0;
                end
            end else if (!bus.stall && !bus.force_nop) begin
                wr_ff   <= 1'b1;
                step_ff <= step_ff + 1'b1;
                unique case (step_ff)
                    3'd0: begin a_ff <= REG_ADDR_LOW;  d_ff <= i_addr[7:0]; end
                    3'd1: begin a_ff <= REG_ADDR_HIGH;
                                d_ff <= {1'b0, i_addr[14:8]}; end
                    3'd2: begin a_ff <= REG_DATA_LOW;  d_ff <= i_data[7:0]; end
                    3'd3: begin a_ff <= REG_DATA_HIGH;
                                d_ff <= {2'b00, i_data[13:8]}; end
                    3'd4: begin a_ff <= REG_CONTROL;   d_ff <= ctl_val; end
                    3'd5: begin a_ff <= REG_UNLOCK;    d_ff <= UNLOCK_KEY_1; end
                    3'd6: begin a_ff <= REG_UNLOCK;    d_ff <= UNLOCK_KEY_2; end
                    3'd7: begin a_ff <= REG_CONTROL;
                                d_ff <= ctl_val | 8'h02; act_ff <= 1'b0; end
                endcase
            end
        end
    end

    // One write per cycle keeps the keys and the trigger back to back.
    assign bus.sfr_wr    = wr_ff;
    assign bus.sfr_addr  = a_ff;
    assign bus.sfr_wdata = d_ff;
    assign bus.sfr_rd    = 1'b0;
    assign o_ready       = !act_ff && !wr_ff && !bus.stall && !bus.force_nop;
endmodule : flash_core_ctrl
`default_nettype wire

// ### hdl/flash_self_write_sequencer.sv
// Device end: flash control registers, latches, row array and timing.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_self_write_sequencer
    import flash_seq_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT  = PROG_CYCLES,
    parameter int ROWS      = 4
) (
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Core side.
    flash_seq_if.device      bus,
    // Array read port.
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [DATA_W-1:0]      o_rd_data,
    output logic                   o_busy
);
    localparam int RB = $clog2(ROWS);
    localparam int CW = 32;

    logic [7:0]        ctl_ff;
    logic [7:0]        addr_lo_ff;
    logic [6:0]        addr_hi_ff;
    logic [7:0]        dat_lo_ff;
    logic [5:0]        dat_hi_ff;
    logic [7:0]        rdata_ff;
    logic [DATA_W-1:0] latch_ff [NUM_LATCHES];
    logic [DATA_W-1:0] mem_ff   [ROWS*NUM_LATCHES];
    logic [DATA_W-1:0] rd_ff;
    seq_state_t        st_ff;
    logic [CW-1:0]     cnt_ff;
    logic              op_erase_ff;
    logic              op_prog_ff;
    logic              armed;
    logic              trig;
    logic              done;
    logic              first_ff;
    logic              keep_ff = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [RB-1:0]     row;
    logic [LATCH_BITS-1:0] col;

    flash_unlock_detect u_unlock (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_wr       (bus.sfr_wr),
        .i_addr     (bus.sfr_addr),
        .i_wdata    (bus.sfr_wdata),
        .o_armed    (armed)
    );

    assign addr = {addr_hi_ff, addr_lo_ff};
    assign row  = addr[LATCH_BITS +: RB];
    assign col  = addr[LATCH_BITS-1:0];
    // Trigger counts only right after the keys and with writes enabled.
    assign trig = armed && bus.sfr_wr && bus.sfr_addr == REG_CONTROL &&
                  bus.sfr_wdata[CTL_TRIGGER] && ctl_ff[CTL_WRITE_ENABLE_BIT] &&
                  !bus.sfr_wdata[CTL_CONFIG_SPACE_SELECT] && st_ff == SEQ_IDLE;
    assign done = (st_ff == SEQ_BUSY && cnt_ff == '0) ||
                  (st_ff == SEQ_SETUP && cnt_ff == '0 &&
                   !op_erase_ff && !op_prog_ff);

    // Operation sequencer.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff       <= SEQ_IDLE;
            cnt_ff      <= '0;
            op_erase_ff <= 1'b0;
            op_prog_ff  <= 1'b0;
        end else begin
            unique case (st_ff)
                SEQ_IDLE: if (trig) begin
                    st_ff       <= SEQ_SETUP;
                    cnt_ff      <= CW'(SETUP_CYCLES - 1);
                    op_erase_ff <= ctl_ff[CTL_ERASE];
                    op_prog_ff  <= !ctl_ff[CTL_ERASE] &&
                                   !ctl_ff[CTL_LATCH_LOAD_ONLY];
                end
                SEQ_SETUP: if (cnt_ff != '0) begin
                    cnt_ff <= cnt_ff - 1'b1;
                end else if (op_erase_ff) begin
                    st_ff  <= SEQ_BUSY;
                    cnt_ff <= CW'(ERASE_CNT - 1);
                end else if (op_prog_ff) begin
                    st_ff  <= SEQ_BUSY;
                    cnt_ff <= CW'(PROG_CNT - 1);
                end else begin
                    st_ff <= SEQ_IDLE;
                end
                SEQ_BUSY: if (cnt_ff != '0) begin
                    cnt_ff <= cnt_ff - 1'b1;
                end else begin
                    st_ff <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Latches: load at trigger, blank after erase or program.
    for (genvar i = 0; i < NUM_LATCHES; i++) begin : g_latch
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                latch_ff[i] <= BLANK_WORD;
            end else if (done && (op_erase_ff || op_prog_ff)) begin
                latch_ff[i] <= BLANK_WORD;
            end else if (trig && !ctl_ff[CTL_ERASE] &&
                         col == LATCH_BITS'(i)) begin
                latch_ff[i] <= {dat_hi_ff, dat_lo_ff};
            end
        end
    end

    // Array model: row erase and programming by clearing bits.
    for (genvar j = 0; j < ROWS*NUM_LATCHES; j++) begin : g_mem
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                mem_ff[j] <= BLANK_WORD;
            end else if (done && row == RB'(j / NUM_LATCHES)) begin
                if (op_erase_ff) begin
                    mem_ff[j] <= BLANK_WORD;
                end else if (op_prog_ff) begin
                    mem_ff[j] <= mem_ff[j] &
                                 latch_ff[j % NUM_LATCHES];
                end
            end
        end
    end

    // Holds whether an operation was running when reset came; power-up is 0.
    always_ff @(posedge i_core_clk) begin
        keep_ff <= i_rst_n ? (st_ff != SEQ_IDLE) : keep_ff;
    end

    // Marks the first cycle after reset is released.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    // Control register and data/address registers.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_ff     <= CONTROL_RESET;
            addr_lo_ff <= '0;
            addr_hi_ff <= '0;
            dat_lo_ff  <= '0;
            dat_hi_ff  <= '0;
        end else begin
            if (bus.sfr_wr && st_ff == SEQ_IDLE) begin
                unique case (bus.sfr_addr)
                    REG_CONTROL: begin
                        ctl_ff[7:4] <= {1'b1, bus.sfr_wdata[6:4]};
                        ctl_ff[CTL_WRITE_ENABLE_BIT] <= bus.sfr_wdata[CTL_WRITE_ENABLE_BIT];
                        ctl_ff[CTL_WRITE_ERROR_FLAG] <= bus.sfr_wdata[CTL_WRITE_ERROR_FLAG];
                        if (trig) begin
                            ctl_ff[CTL_TRIGGER] <= 1'b1;
                        end
                    end
                    REG_ADDR_LOW:  addr_lo_ff <= bus.sfr_wdata;
                    REG_ADDR_HIGH: addr_hi_ff <= bus.sfr_wdata[6:0];
                    REG_DATA_LOW:  dat_lo_ff  <= bus.sfr_wdata;
                    REG_DATA_HIGH: dat_hi_ff  <= bus.sfr_wdata[5:0];
                    default: ;
                endcase
            end
            if (done) begin
                ctl_ff[CTL_TRIGGER] <= 1'b0;
                if (op_erase_ff) begin
                    ctl_ff[CTL_ERASE] <= 1'b0;
                end
            end
            if (first_ff && keep_ff) begin
                ctl_ff[CTL_WRITE_ERROR_FLAG] <= 1'b1;
            end
        end
    end

    // Read data, one cycle after the strobe.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= '0;
            rd_ff    <= BLANK_WORD;
        end else begin
            rd_ff <= mem_ff[i_rd_addr[LATCH_BITS+RB-1:0]];
            if (bus.sfr_rd) begin
                unique case (bus.sfr_addr)
                    REG_CONTROL:   rdata_ff <= ctl_ff;
                    REG_ADDR_LOW:  rdata_ff <= addr_lo_ff;
                    REG_ADDR_HIGH: rdata_ff <= {1'b1, addr_hi_ff};
                    REG_DATA_LOW:  rdata_ff <= dat_lo_ff;
                    REG_DATA_HIGH: rdata_ff <= {2'b00, dat_hi_ff};
                    default:       rdata_ff <= '0;
                endcase
            end else begin
                rdata_ff <= '0;
            end
        end
    end

    assign bus.sfr_rdata = rdata_ff;
    assign bus.force_nop = (st_ff == SEQ_SETUP);
    assign bus.stall     = (st_ff == SEQ_BUSY);
    assign o_busy        = (st_ff != SEQ_IDLE);
    assign o_rd_data     = rd_ff;
endmodule : flash_self_write_sequencer
`default_nettype wire

// ### hdl/flash_seq_if.sv
// Interface joining the core-side controller and the flash sequencer.
`timescale 1ns/1ps
`default_nettype none
interface flash_seq_if;
    logic [2:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic       force_nop;
    logic       stall;
    modport device (
        input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd,
        output sfr_rdata, force_nop, stall
    );
    modport core (
        output sfr_addr, sfr_wdata, sfr_wr, sfr_rd,
        input  sfr_rdata, force_nop, stall
    );
endinterface : flash_seq_if
`default_nettype wire

// ### hdl/flash_seq_pkg.sv
// Package with constants and types shared by both ends of the flash sequencer.
package flash_seq_pkg;
    localparam int          ADDR_W          = 15;
    localparam int          DATA_W          = 14;
    localparam int          LATCH_BITS      = 4;
    localparam int          NUM_LATCHES     = 16;
    localparam logic [13:0] BLANK_WORD      = 14'h3fff;
    localparam logic [7:0]  UNLOCK_KEY_1    = 8'h55;
    localparam logic [7:0]  UNLOCK_KEY_2    = 8'haa;
    localparam int          SETUP_CYCLES    = 2;
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          ERASE_TIME_US   = 2000;
    localparam int          PROG_TIME_US    = 2000;
    localparam int          ERASE_CYCLES    = ERASE_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int          PROG_CYCLES     = PROG_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam logic [2:0]  REG_CONTROL     = 3'h0;
    localparam logic [2:0]  REG_UNLOCK      = 3'h1;
    localparam logic [2:0]  REG_ADDR_LOW    = 3'h2;
    localparam logic [2:0]  REG_ADDR_HIGH   = 3'h3;
    localparam logic [2:0]  REG_DATA_LOW    = 3'h4;
    localparam logic [2:0]  REG_DATA_HIGH   = 3'h5;
    localparam int          CTL_TRIGGER     = 1;
    localparam int          CTL_WRITE_ENABLE_BIT        = 2;
    localparam int          CTL_WRITE_ERROR_FLAG       = 3;
    localparam int          CTL_ERASE       = 4;
    localparam int          CTL_LATCH_LOAD_ONLY        = 5;
    localparam int          CTL_CONFIG_SPACE_SELECT        = 6;
    localparam logic [7:0]  CONTROL_RESET   = 8'h80;
    localparam logic [7:0]  ADDR_HIGH_FILL  = 8'h80;
    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_KEY1,
        UNL_KEY2
    } unlock_state_t;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SETUP,
        SEQ_BUSY
    } seq_state_t;
endpackage : flash_seq_pkg

// ### hdl/flash_unlock_detect.sv
// Unlock key detector for the flash sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_unlock_detect
    import flash_seq_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    // Register write observed.
    input  wire logic       i_wr,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    // Detector result.
    output logic            o_armed
);
    unlock_state_t state_ff;
    unlock_state_t nxt_state;

    // An idle cycle or any other write between the keys drops the sequence.
    always_comb begin
        nxt_state = UNL_IDLE;
        unique case (state_ff)
            UNL_IDLE: nxt_state = (i_wr && i_addr == REG_UNLOCK &&
                i_wdata == UNLOCK_KEY_1) ? UNL_KEY1 : UNL_IDLE;
            UNL_KEY1: nxt_state = (i_wr && i_addr == REG_UNLOCK &&
                i_wdata == UNLOCK_KEY_2) ? UNL_KEY2 : UNL_IDLE;
            UNL_KEY2: nxt_state = UNL_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= UNL_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Armed only in the cycle right after both keys.
    assign o_armed = (state_ff == UNL_KEY2);
endmodule : flash_unlock_detect
`default_nettype wire

// ### tb/flash_self_write_sequencer_tb.sv
// Testbench for the core controller and flash sequencer pair.
`timescale 1ns/1ps
`default_nettype none
module flash_self_write_sequencer_tb
    import flash_seq_pkg::*;
;
    localparam int CNT = 20;
    logic              i_core_clk = 1'b0;
    logic              i_rst_n    = 1'b0;
    logic              start      = 1'b0;
    logic              erase      = 1'b0;
    logic              last       = 1'b0;
    logic [ADDR_W-1:0] addr       = '0;
    logic [DATA_W-1:0] data       = '0;
    logic [ADDR_W-1:0] rd_addr    = '0;
    logic [DATA_W-1:0] rd1;
    logic [DATA_W-1:0] rd2;
    logic              ready;
    logic              busy2;
    logic [DATA_W-1:0] d [3];
    logic [DATA_W-1:0] g;
    logic [DATA_W-1:0] h;
    logic [DATA_W-1:0] e;
    int                failures   = 0;
    int                tests_run  = 0;
    flash_seq_if ifc ();
    flash_seq_if ifd ();
    always #2 i_core_clk = ~i_core_clk;
    flash_core_ctrl flash_core_ctrl_i (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_start(start), .i_erase(erase), .i_last(last),
        .i_addr(addr), .i_data(data), .o_ready(ready), .bus(ifc));
    flash_self_write_sequencer #(.ERASE_CNT(CNT), .PROG_CNT(CNT))
        flash_self_write_sequencer_i (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .bus(ifc), .i_rd_addr(rd_addr), .o_rd_data(rd1),
        .o_busy());
    flash_self_write_sequencer #(.ERASE_CNT(CNT), .PROG_CNT(CNT))
        flash_self_write_sequencer_i2 (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .bus(ifd), .i_rd_addr(rd_addr), .o_rd_data(rd2),
        .o_busy(busy2));
    flash_seq_monitor #(.CNT(CNT)) flash_seq_monitor_i (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .sfr_addr(ifc.sfr_addr),
        .sfr_wdata(ifc.sfr_wdata), .sfr_wr(ifc.sfr_wr), .sfr_rd(ifc.sfr_rd),
        .sfr_rdata(ifc.sfr_rdata), .force_nop(ifc.force_nop),
        .stall(ifc.stall));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic int busy_len(input logic [7:0] c);
        if (!c[CTL_WRITE_ENABLE_BIT]) return 0;
        return SETUP_CYCLES + ((c[CTL_LATCH_LOAD_ONLY] && !c[CTL_ERASE]) ? 0 : CNT);
    endfunction : busy_len
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        ifd.sfr_addr  <= a;
        ifd.sfr_wdata <= v;
        ifd.sfr_wr    <= 1'b1;
        @(posedge i_core_clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        ifd.sfr_addr <= a;
        ifd.sfr_rd   <= 1'b1;
        @(posedge i_core_clk);
        ifd.sfr_rd <= 1'b0;
        @(negedge i_core_clk);
        chk({8'h00, ifd.sfr_rdata}, {8'h00, exp});
        @(posedge i_core_clk);
    endtask : rd
    task automatic ard(input logic [ADDR_W-1:0] a);
        rd_addr <= a;
        @(posedge i_core_clk);
        @(negedge i_core_clk);
        g = rd1;
        h = rd2;
        @(posedge i_core_clk);
    endtask : ard
    task automatic setw(input logic [7:0] a, input logic [DATA_W-1:0] v);
        wr(REG_ADDR_LOW, a);
        wr(REG_ADDR_HIGH, 8'h00);
        wr(REG_DATA_LOW, v[7:0]);
        wr(REG_DATA_HIGH, {2'b00, v[13:8]});
    endtask : setw
    // Keys go back to back unless brk puts an idle cycle between them.
    task automatic unlock(input logic [7:0] c, input logic brk);
        int k;
        int n;
        n = 0;
        wr(REG_CONTROL, c);
        wr(REG_UNLOCK, UNLOCK_KEY_1);
        if (brk) begin
            ifd.sfr_wr <= 1'b0;
            @(posedge i_core_clk);
        end
        wr(REG_UNLOCK, UNLOCK_KEY_2);
        wr(REG_CONTROL, c | 8'h02);
        ifd.sfr_wr <= 1'b0;
        for (k = 0; k < 60; k++) begin
            @(negedge i_core_clk);
            if (busy2 === 1'b1) n++;
        end
        @(posedge i_core_clk);
        chk(16'(n), 16'(brk ? 0 : busy_len(c)));
    endtask : unlock
    task automatic order(input logic e, input logic l,
                         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        int k;
        erase <= e;
        last  <= l;
        addr  <= a;
        data  <= v;
        start <= 1'b1;
        @(posedge i_core_clk);
        start <= 1'b0;
        for (k = 0; k < 500; k++) begin
            @(negedge i_core_clk);
            if (k > 1 && ready === 1'b1) break;
        end
        if (k == 500) begin
            failures++;
            print_verdict();
        end
        @(posedge i_core_clk);
    endtask : order
    initial begin
        ifd.sfr_addr  = 3'h0;
        ifd.sfr_wdata = 8'h00;
        ifd.sfr_wr    = 1'b0;
        ifd.sfr_rd    = 1'b0;
        void'($urandom(70058));
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rd(REG_CONTROL, CONTROL_RESET);
        rd(REG_ADDR_HIGH, ADDR_HIGH_FILL);
        rd(REG_UNLOCK, 8'h00);
        rd(3'h7, 8'h00);
        for (int i = 0; i < 3; i++) begin
            d[i] = DATA_W'($urandom);
            order(1'b0, i == 2, ADDR_W'(17 + 5 * i), d[i]);
        end
        for (int i = 16; i < 33; i++) begin
            ard(ADDR_W'(i));
            chk(16'(g), 16'((i % 5 == 2 && i < 32) ? d[(i - 17) / 5]
                : BLANK_WORD));
        end
        e = DATA_W'($urandom);
        order(1'b0, 1'b1, ADDR_W'(22), e);
        order(1'b0, 1'b1, ADDR_W'(47), e);
        ard(ADDR_W'(22));
        chk(16'(g), 16'(d[1] & e));
        order(1'b1, 1'b1, ADDR_W'(28), 14'h0000);
        for (int i = 16; i < 32; i += 3) begin
            ard(ADDR_W'(i));
            chk(16'(g), 16'(BLANK_WORD));
        end
        ard(ADDR_W'(47));
        chk(16'(g), 16'(e));
        order(1'b1, 1'b1, ADDR_W'(40), 14'h0000);
        ard(ADDR_W'(47));
        chk(16'(g), 16'(BLANK_WORD));
        order(1'b0, 1'b1, ADDR_W'(47), e);
        ard(ADDR_W'(47));
        chk(16'(g), 16'(e));
        setw(8'h05, 14'h1234);
        unlock(8'h24, 1'b1);
        unlock(8'h20, 1'b0);
        unlock(8'h24, 1'b0);
        ard(ADDR_W'(5));
        chk(16'(h), 16'(BLANK_WORD));
        setw(8'h09, 14'h0abc);
        unlock(8'h04, 1'b0);
        ard(ADDR_W'(5));
        chk(16'(h), 16'h1234);
        ard(ADDR_W'(9));
        chk(16'(h), 16'h0abc);
        rd(REG_CONTROL, 8'h84);
        unlock(8'h14, 1'b0);
        ard(ADDR_W'(9));
        chk(16'(h), 16'(BLANK_WORD));
        rd(REG_CONTROL, 8'h84);
        wr(REG_CONTROL, 8'h14);
        wr(REG_UNLOCK, UNLOCK_KEY_1);
        wr(REG_UNLOCK, UNLOCK_KEY_2);
        wr(REG_CONTROL, 8'h16);
        ifd.sfr_wr <= 1'b0;
        rd(REG_CONTROL, 8'h96);
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rd(REG_CONTROL, 8'h88);
        print_verdict();
    end
endmodule : flash_self_write_sequencer_tb
`default_nettype wire

// ### tb/flash_seq_monitor.sv
// Checker on the link between the core controller and the sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_monitor
    import flash_seq_pkg::*;
#(
    parameter int CNT = 20
) (
    // Clock and reset.
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    // Link signals.
    input wire logic [2:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       force_nop,
    input wire logic       stall
);
    logic key1_ff;
    logic key2_ff;
    logic wen_ff;
    logic op_ff;
    int   cnt_ff;
    logic ctl_wr;
    logic trig;
    assign ctl_wr = sfr_wr && sfr_addr == REG_CONTROL;
    assign trig   = key2_ff && ctl_wr && wen_ff && sfr_wdata[CTL_TRIGGER]
                    && sfr_wdata[CTL_WRITE_ENABLE_BIT] && !sfr_wdata[CTL_CONFIG_SPACE_SELECT];
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key1_ff <= 1'b0;
            key2_ff <= 1'b0;
        end else begin
            key1_ff <= sfr_wr && sfr_addr == REG_UNLOCK
                       && sfr_wdata == UNLOCK_KEY_1;
            key2_ff <= key1_ff && sfr_wr && sfr_addr == REG_UNLOCK
                       && sfr_wdata == UNLOCK_KEY_2;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wen_ff <= 1'b0;
            op_ff  <= 1'b0;
        end else if (ctl_wr && !force_nop && !stall) begin
            wen_ff <= sfr_wdata[CTL_WRITE_ENABLE_BIT];
            op_ff  <= sfr_wdata[CTL_ERASE] || !sfr_wdata[CTL_LATCH_LOAD_ONLY];
        end
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 0;
        end else begin
            cnt_ff <= stall ? cnt_ff + 1 : 0;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_trig_nop : assert property (
        trig |=> force_nop ##1 force_nop ##1 !force_nop)
        else $error("forced no-ops not two cycles after trigger");
    a_nop_cause : assert property (
        $rose(force_nop) |-> $past(trig))
        else $error("no-ops without a complete unlock sequence");
    a_stall_mode : assert property (
        $fell(force_nop) |-> stall == op_ff)
        else $error("stall does not match the operation kind");
    a_stall_start : assert property (
        $rose(stall) |-> $past(force_nop) && !force_nop)
        else $error("stall began without the forced no-ops");
    a_stall_len : assert property (
        $fell(stall) |-> cnt_ff == CNT)
        else $error("stall length differs from the timed count");
    a_stall_bound : assert property (
        stall |-> cnt_ff < CNT)
        else $error("stall runs past the timed count");
    a_nop_excl : assert property (
        !(force_nop && stall))
        else $error("no-op and stall high together");
    a_stall_kind : assert property (
        $rose(stall) |-> op_ff)
        else $error("latch load stalled the core");
endmodule : flash_seq_monitor
`default_nettype wire
